// file: acspc_pkg.sv
package acspc_pkg;

  // ==========================================================================
  // Register addresses and reset values
  // ==========================================================================
  localparam logic [7:0] ADDR_CLOCK_SOURCE_CONFIG = 8'h16;
  localparam logic [7:0] ADDR_PDM_CLOCK_CONFIG = 8'h1f;
  localparam logic [7:0] ADDR_PDM_INPUT_EDGE_CONFIG = 8'h20;
  localparam logic [7:0] RESET_CLOCK_SOURCE_CONFIG = 8'h10;
  localparam logic [7:0] RESET_PDM_CLOCK_CONFIG = 8'h40;
  localparam logic [7:0] RESET_PDM_INPUT_EDGE_CONFIG = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CSC_ROOT_SELECT_BIT = 7;
  localparam int CSC_FREQ_MODE_BIT = 6;
  localparam int CSC_RATIO_HI = 5;
  localparam int CSC_RATIO_LO = 3;
  localparam int CSC_INVERT_BIT = 1;
  localparam int PCC_DIVIDER_HI = 1;
  localparam int PCC_DIVIDER_LO = 0;
  localparam int PIE_EDGE_BIT = 7;
  // Only bits 7 and 6 of the edge register store; bits 5-0 read as zero.
  localparam logic [7:0] PIE_WRITABLE_MASK = 8'hc0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint CLK_SYS_HZ = 50_000_000;
  localparam int PHASE_BITS = 32;
  localparam longint PDM_HZ_44K_C0 = 2_822_400;
  localparam longint PDM_HZ_44K_C1 = 1_411_200;
  localparam longint PDM_HZ_44K_C2 = 705_600;
  localparam longint PDM_HZ_44K_C3 = 5_644_800;
  localparam longint PDM_HZ_48K_C0 = 3_072_000;
  localparam longint PDM_HZ_48K_C1 = 1_536_000;
  localparam longint PDM_HZ_48K_C2 = 768_000;
  localparam longint PDM_HZ_48K_C3 = 6_144_000;

  typedef enum logic [1:0] {ROOT_PLL, ROOT_BITCLK, ROOT_MCLK} acspc_root_e;

  // Phase increment that makes the accumulator overflow at the given rate.
  function automatic logic [31:0] acspc_step(input longint hz);
    longint q;
    q = (hz << PHASE_BITS) / CLK_SYS_HZ;
    return q[31:0];
  endfunction

  function automatic logic [31:0] acspc_pdm_step(input logic fam_44k, input logic [1:0] code);
    unique case ({fam_44k, code})
      3'h0: return acspc_step(PDM_HZ_48K_C0);
      3'h1: return acspc_step(PDM_HZ_48K_C1);
      3'h2: return acspc_step(PDM_HZ_48K_C2);
      3'h3: return acspc_step(PDM_HZ_48K_C3);
      3'h4: return acspc_step(PDM_HZ_44K_C0);
      3'h5: return acspc_step(PDM_HZ_44K_C1);
      3'h6: return acspc_step(PDM_HZ_44K_C2);
      3'h7: return acspc_step(PDM_HZ_44K_C3);
    endcase
  endfunction

  function automatic logic [11:0] acspc_mclk_ratio(input logic [2:0] code);
    unique case (code)
      3'h0: return 12'h040;
      3'h1: return 12'h100;
      3'h2: return 12'h180;
      3'h3: return 12'h200;
      3'h4: return 12'h300;
      3'h5: return 12'h400;
      3'h6: return 12'h600;
      3'h7: return 12'h900;
    endcase
  endfunction

  function automatic logic [15:0] acspc_mclk_khz(input logic [2:0] code);
    unique case (code)
      3'h0: return 16'h2ee0;
      3'h1: return 16'h3000;
      3'h2: return 16'h32c8;
      3'h3: return 16'h3e80;
      3'h4: return 16'h4b00;
      3'h5: return 16'h4ce0;
      3'h6: return 16'h5dc0;
      3'h7: return 16'h6000;
    endcase
  endfunction

endpackage

// file: acspc_pdm_if.sv
`timescale 1ns/100ps
`default_nettype none

interface acspc_pdm_if;
  logic level;
  logic rise;
  logic fall;
  modport gen (output level, output rise, output fall);
  modport use_side (input level, input rise, input fall);
endinterface

`default_nettype wire

// file: acspc_pdm_clkgen.sv
`timescale 1ns/100ps
`default_nettype none

module acspc_pdm_clkgen
  import acspc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic enable,
  input wire logic [31:0] step,
  // Clock events
  acspc_pdm_if.gen pdm
);

  logic [31:0] phase_reg;
  logic [31:0] phase_next;
  logic level_reg;

  // The accumulator wraps on purpose; the carry out of bit 31 is dropped.
  assign phase_next = enable ? 32'(phase_reg + step) : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_reg <= 32'h0000_0000;
      level_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      level_reg <= phase_next[31];
    end
  end

  assign pdm.level = level_reg;
  assign pdm.rise = phase_next[31] & ~level_reg;
  assign pdm.fall = ~phase_next[31] & level_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_no_clock_when_off;
    @(posedge clk_sys) disable iff (rst) !enable |=> !level_reg;
  endproperty
  a_no_clock_when_off: assert property (p_no_clock_when_off)
    else $error("Divided clock runs while disabled.");

endmodule

`default_nettype wire

// file: acspc_pdm_latch.sv
`timescale 1ns/100ps
`default_nettype none

module acspc_pdm_latch
  import acspc_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control and line
  input wire logic swap_edges,
  input wire logic line_data,
  acspc_pdm_if.use_side pdm,
  // Latched channel bits
  output logic [CHANNELS-1:0] chan_bit,
  output logic [CHANNELS-1:0] chan_valid
);

  logic data_meta_reg;
  logic data_sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_meta_reg <= 1'b0;
      data_sync_reg <= 1'b0;
    end else begin
      data_meta_reg <= line_data;
      data_sync_reg <= data_meta_reg;
    end
  end

  // Even channels take the falling edge by default, odd ones the rising edge.
  for (genvar k = 0; k < CHANNELS; k++) begin : g_chan
    logic take;
    assign take = ((k % 2 == 1) ^ swap_edges) ? pdm.rise : pdm.fall;
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        chan_bit[k] <= 1'b0;
        chan_valid[k] <= 1'b0;
      end else begin
        chan_valid[k] <= take;
        if (take) begin
          chan_bit[k] <= data_sync_reg;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_first_channel_edge;
    @(posedge clk_sys) disable iff (rst)
      (swap_edges ? pdm.rise : pdm.fall) |=> chan_valid[0] && chan_bit[0] == $past(data_sync_reg);
  endproperty
  a_first_channel_edge: assert property (p_first_channel_edge)
    else $error("Channel 1 latched on the wrong edge.");

  property p_second_channel_edge;
    @(posedge clk_sys) disable iff (rst)
      (swap_edges ? pdm.fall : pdm.rise) |=> chan_valid[1] && !chan_valid[0];
  endproperty
  a_second_channel_edge: assert property (p_second_channel_edge)
    else $error("Channel 2 latched on the wrong edge.");

endmodule

`default_nettype wire

// file: acspc_top.sv
`timescale 1ns/100ps
`default_nettype none

module acspc_top
  import acspc_pkg::*;
#(
  parameter int PDM_CHANNELS = 2
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register access from the control port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Settings held by neighbouring registers
  input wire logic role_select,
  input wire logic auto_clock_enable,
  input wire logic auto_mode_pll_disable,
  input wire logic sample_rate_family,
  input wire logic [2:0] master_clock_freq_code,
  input wire logic pdm_enable,
  // Serial bit clock pin
  input wire logic bitclk_in,
  // Clock plan results
  output acspc_root_e root_select,
  output logic pll_enable,
  output logic master_clock_freq_mode,
  output logic [15:0] master_clock_khz,
  output logic [11:0] master_clock_ratio,
  output logic frame_gen_bitclk,
  // PDM microphones
  output logic pdm_clock_out,
  input wire logic pdm_line1_data,
  output logic [PDM_CHANNELS-1:0] pdm_chan_bit,
  output logic [PDM_CHANNELS-1:0] pdm_chan_valid
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] clock_source_config_reg;
  logic [7:0] pdm_clock_config_reg;
  logic [7:0] pdm_input_edge_config_reg;
  logic [7:0] reg_rdata_reg;
  logic reg_rvalid_reg;

  logic wr_source;
  logic wr_pdm_clock;
  logic wr_edge;

  assign wr_source = reg_wr && reg_addr == ADDR_CLOCK_SOURCE_CONFIG;
  assign wr_pdm_clock = reg_wr && reg_addr == ADDR_PDM_CLOCK_CONFIG;
  assign wr_edge = reg_wr && reg_addr == ADDR_PDM_INPUT_EDGE_CONFIG;

  // Reserved bits 2 and 0 store whatever is written; software keeps them zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clock_source_config_reg <= RESET_CLOCK_SOURCE_CONFIG;
    end else if (wr_source) begin
      clock_source_config_reg <= reg_wdata;
    end
  end

  // Bits 7-2 are stored as written so the reserved pattern reads back.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdm_clock_config_reg <= RESET_PDM_CLOCK_CONFIG;
    end else if (wr_pdm_clock) begin
      pdm_clock_config_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdm_input_edge_config_reg <= RESET_PDM_INPUT_EDGE_CONFIG;
    end else if (wr_edge) begin
      pdm_input_edge_config_reg <= reg_wdata & PIE_WRITABLE_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_reg <= 8'h00;
      reg_rvalid_reg <= 1'b0;
    end else begin
      reg_rvalid_reg <= reg_rd;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CLOCK_SOURCE_CONFIG: reg_rdata_reg <= clock_source_config_reg;
          ADDR_PDM_CLOCK_CONFIG: reg_rdata_reg <= pdm_clock_config_reg;
          ADDR_PDM_INPUT_EDGE_CONFIG: reg_rdata_reg <= pdm_input_edge_config_reg;
          default: reg_rdata_reg <= UNMAPPED_READ_VALUE;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign reg_rvalid = reg_rvalid_reg;

  // ==========================================================================
  // Clock plan
  // ==========================================================================
  logic root_bit;
  logic freq_mode_bit;
  logic [2:0] ratio_code;
  logic invert_bitclk_for_frame_gen;
  logic pll_off_slave;
  acspc_root_e root_select_reg;
  logic pll_enable_reg;
  logic freq_mode_reg;
  logic [15:0] master_clock_khz_reg;
  logic [11:0] master_clock_ratio_reg;

  assign root_bit = clock_source_config_reg[CSC_ROOT_SELECT_BIT];
  assign freq_mode_bit = clock_source_config_reg[CSC_FREQ_MODE_BIT];
  assign ratio_code = clock_source_config_reg[CSC_RATIO_HI:CSC_RATIO_LO];
  assign invert_bitclk_for_frame_gen = clock_source_config_reg[CSC_INVERT_BIT];
  // Slave role, auto clocking, PLL switched off.
  assign pll_off_slave = !role_select && auto_clock_enable && auto_mode_pll_disable;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      root_select_reg <= ROOT_PLL;
    end else if (!pll_off_slave) begin
      root_select_reg <= ROOT_PLL;
    end else if (root_bit) begin
      root_select_reg <= ROOT_MCLK;
    end else begin
      root_select_reg <= ROOT_BITCLK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_enable_reg <= 1'b1;
    end else begin
      pll_enable_reg <= !(auto_clock_enable && auto_mode_pll_disable);
    end
  end

  // The ratio applies in master mode or with the master clock as slave root.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      master_clock_ratio_reg <= 12'h000;
    end else if (role_select || pll_off_slave && root_bit) begin
      master_clock_ratio_reg <= acspc_mclk_ratio(ratio_code);
    end else begin
      master_clock_ratio_reg <= 12'h000;
    end
  end

  // Fixed frequency is reported only when the fixed-code mode is in force.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_mode_reg <= 1'b0;
      master_clock_khz_reg <= 16'h0000;
    end else begin
      freq_mode_reg <= auto_clock_enable && freq_mode_bit;
      if (auto_clock_enable && role_select && !freq_mode_bit) begin
        master_clock_khz_reg <= acspc_mclk_khz(master_clock_freq_code);
      end else begin
        master_clock_khz_reg <= 16'h0000;
      end
    end
  end

  assign root_select = root_select_reg;
  assign pll_enable = pll_enable_reg;
  assign master_clock_freq_mode = freq_mode_reg;
  assign master_clock_khz = master_clock_khz_reg;
  assign master_clock_ratio = master_clock_ratio_reg;

  // ==========================================================================
  // Bit clock for frame generation
  // ==========================================================================
  logic bitclk_meta_reg;
  logic bitclk_sync_reg;
  logic frame_gen_bitclk_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bitclk_meta_reg <= 1'b0;
      bitclk_sync_reg <= 1'b0;
    end else begin
      bitclk_meta_reg <= bitclk_in;
      bitclk_sync_reg <= bitclk_meta_reg;
    end
  end

  // Only the frame generator sees the inverted copy; other users keep the pin.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_gen_bitclk_reg <= 1'b0;
    end else begin
      frame_gen_bitclk_reg <= bitclk_sync_reg ^ (role_select && invert_bitclk_for_frame_gen);
    end
  end

  assign frame_gen_bitclk = frame_gen_bitclk_reg;

  // ==========================================================================
  // PDM clock and data line 1
  // ==========================================================================
  logic [1:0] pdm_clock_divider;
  logic pdm_line1_latch_edge;
  logic [31:0] pdm_step;

  acspc_pdm_if pdm_bus ();

  assign pdm_clock_divider = pdm_clock_config_reg[PCC_DIVIDER_HI:PCC_DIVIDER_LO];
  assign pdm_line1_latch_edge = pdm_input_edge_config_reg[PIE_EDGE_BIT];
  // Code 3 is meant for channels 1 and 2 only; the divider does not police it.
  assign pdm_step = acspc_pdm_step(sample_rate_family, pdm_clock_divider);

  acspc_pdm_clkgen u_clkgen (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(pdm_enable),
    .step(pdm_step),
    .pdm(pdm_bus.gen)
  );

  acspc_pdm_latch #(
    .CHANNELS(PDM_CHANNELS)
  ) u_latch (
    .clk_sys(clk_sys),
    .rst(rst),
    .swap_edges(pdm_line1_latch_edge),
    .line_data(pdm_line1_data),
    .pdm(pdm_bus.use_side),
    .chan_bit(pdm_chan_bit),
    .chan_valid(pdm_chan_valid)
  );

  assign pdm_clock_out = pdm_bus.level;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_source_reset;
    $fell(rst) |-> clock_source_config_reg == 8'h10 && pdm_clock_config_reg == 8'h40;
  endproperty
  a_source_reset: assert property (p_source_reset)
    else $error("Register reset values wrong.");

  property p_edge_low_bits;
    wr_edge |=> pdm_input_edge_config_reg[5:0] == 6'h00
      && pdm_input_edge_config_reg[7:6] == $past(reg_wdata[7:6]);
  endproperty
  a_edge_low_bits: assert property (p_edge_low_bits)
    else $error("Edge register low bits not read-only zero.");

  property p_readback;
    reg_rd && reg_addr == 8'h1f && !wr_pdm_clock |=> reg_rvalid && reg_rdata == pdm_clock_config_reg;
  endproperty
  a_readback: assert property (p_readback)
    else $error("PDM clock register read back wrong.");

  property p_root_mclk;
    pll_off_slave && root_bit ##1 pll_off_slave && root_bit |-> root_select == ROOT_MCLK;
  endproperty
  a_root_mclk: assert property (p_root_mclk)
    else $error("Master clock not chosen as root.");

  property p_root_bitclk;
    pll_off_slave && !root_bit |=> root_select == ROOT_BITCLK;
  endproperty
  a_root_bitclk: assert property (p_root_bitclk)
    else $error("Bit clock not chosen as root.");

  property p_ratio_2304;
    role_select && ratio_code == 3'h7 |=> master_clock_ratio == 12'h900;
  endproperty
  a_ratio_2304: assert property (p_ratio_2304)
    else $error("Ratio code 7 does not give 2304.");

  property p_inversion;
    role_select && invert_bitclk_for_frame_gen ##1 role_select && invert_bitclk_for_frame_gen
      |-> frame_gen_bitclk == !$past(bitclk_sync_reg);
  endproperty
  a_inversion: assert property (p_inversion)
    else $error("Frame bit clock not inverted.");

  property p_slave_no_invert;
    !role_select |=> frame_gen_bitclk == $past(bitclk_sync_reg);
  endproperty
  a_slave_no_invert: assert property (p_slave_no_invert)
    else $error("Bit clock inverted outside master mode.");

  property p_pll_off;
    auto_clock_enable && auto_mode_pll_disable |=> !pll_enable;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("PLL not disabled.");

  property p_fixed_khz;
    auto_clock_enable && role_select && !freq_mode_bit && master_clock_freq_code == 3'h7
      |=> master_clock_khz == 16'h6000 && !master_clock_freq_mode;
  endproperty
  a_fixed_khz: assert property (p_fixed_khz)
    else $error("Fixed master clock frequency wrong.");

  property p_pdm_toggles;
    pdm_enable && $stable(pdm_step) [*8] |-> ##[1:40] $changed(pdm_clock_out);
  endproperty
  a_pdm_toggles: assert property (p_pdm_toggles)
    else $error("PDM clock does not toggle.");

  c_root_mclk: cover property (root_select == ROOT_MCLK);
  c_fastest_pdm: cover property (pdm_clock_divider == 2'h3 && pdm_bus.rise);
  c_swapped_latch: cover property (pdm_line1_latch_edge && pdm_chan_valid[0]);
  c_inverted_frame: cover property (role_select && invert_bitclk_for_frame_gen);

endmodule

`default_nettype wire

// file: acspc_mic_model.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Two microphones sharing PDM data line 1
// ==========================================================================
module acspc_mic_model (
  // Clock from the device
  input wire logic pdm_clock_out,
  // Bit that each microphone sends
  input wire logic bit_high,
  input wire logic bit_low,
  // Shared data line
  output logic pdm_line1_data
);
  // One microphone drives while the clock is high, the other while it is low.
  assign pdm_line1_data = pdm_clock_out ? bit_high : bit_low;
endmodule

`default_nettype wire

// file: test_audio_clock_source_pdm_config.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: %0h expected %0h", $time, got, exp); end end

module test_audio_clock_source_pdm_config
  import acspc_pkg::*;
();
  // ==========================================================================
  // Signals and tables
  // ==========================================================================
  logic clk_sys, rst, reg_wr, reg_rd, reg_rvalid, role_select, auto_clock_enable;
  logic auto_mode_pll_disable, sample_rate_family, pdm_enable, bitclk_in, pll_enable;
  logic master_clock_freq_mode, frame_gen_bitclk, pdm_clock_out, pdm_line1_data;
  logic bit_high, bit_low;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] master_clock_freq_code, k;
  logic [15:0] master_clock_khz;
  logic [11:0] master_clock_ratio;
  logic [1:0] pdm_chan_bit, pdm_chan_valid;
  acspc_root_e root_select;
  int failures = 0;
  int num_checks = 0;
  int cyc, exp_cyc;
  logic [11:0] ratio_tab [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
                                 12'h300, 12'h400, 12'h600, 12'h900};
  logic [15:0] khz_tab [8] = '{16'h2ee0, 16'h3000, 16'h32c8, 16'h3e80,
                               16'h4b00, 16'h4ce0, 16'h5dc0, 16'h6000};
  int pdm_hz [8] = '{32'h2ee000, 32'h177000, 32'hbb800, 32'h5dc000,
                     32'h2b1100, 32'h158880, 32'hac440, 32'h562200};

  acspc_top dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .role_select(role_select), .auto_clock_enable(auto_clock_enable),
    .auto_mode_pll_disable(auto_mode_pll_disable), .sample_rate_family(sample_rate_family),
    .master_clock_freq_code(master_clock_freq_code), .pdm_enable(pdm_enable),
    .bitclk_in(bitclk_in), .root_select(root_select), .pll_enable(pll_enable),
    .master_clock_freq_mode(master_clock_freq_mode), .master_clock_khz(master_clock_khz),
    .master_clock_ratio(master_clock_ratio), .frame_gen_bitclk(frame_gen_bitclk),
    .pdm_clock_out(pdm_clock_out), .pdm_line1_data(pdm_line1_data),
    .pdm_chan_bit(pdm_chan_bit), .pdm_chan_valid(pdm_chan_valid)
  );

  acspc_mic_model mic (
    .pdm_clock_out(pdm_clock_out), .bit_high(bit_high), .bit_low(bit_low),
    .pdm_line1_data(pdm_line1_data)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timed_out;
    failures++;
    $display("wrong value at %0t: wait expired", $time);
    end_sim();
  endtask

  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk_sys);
    if (reg_rvalid !== 1'b1) timed_out();
    `CHK(reg_rdata, exp)
    @(negedge clk_sys);
  endtask

  // Counts system cycles spanned by n PDM clock periods.
  task automatic measure(input int n, output int c);
    int seen;
    logic prev;
    seen = 0;
    c = 0;
    prev = pdm_clock_out;
    for (int i = 0; i < 20000 && seen <= n; i++) begin
      @(negedge clk_sys);
      if (seen > 0) c++;
      if (pdm_clock_out === 1'b1 && prev === 1'b0) seen++;
      prev = pdm_clock_out;
    end
    if (seen <= n) timed_out();
  endtask

  task automatic wait_valid(input int ch);
    int n;
    for (n = 0; n < 500 && pdm_chan_valid[ch] !== 1'b1; n++) @(negedge clk_sys);
    if (pdm_chan_valid[ch] !== 1'b1) timed_out();
    @(negedge clk_sys);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {role_select, auto_clock_enable, auto_mode_pll_disable} = 3'b000;
    {sample_rate_family, pdm_enable, bitclk_in, bit_high, bit_low} = 5'h00;
    master_clock_freq_code = 3'h0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    rd(ADDR_CLOCK_SOURCE_CONFIG, 8'h10);
    rd(ADDR_PDM_CLOCK_CONFIG, 8'h40);
    rd(ADDR_PDM_INPUT_EDGE_CONFIG, 8'h00);
    rd(8'h30, 8'h00);
    `CHK(root_select, ROOT_PLL)
    `CHK(pll_enable, 1'b1)
    $display("test reset values done");
    wr(ADDR_CLOCK_SOURCE_CONFIG, 8'hfa);
    rd(ADDR_CLOCK_SOURCE_CONFIG, 8'hfa);
    wr(ADDR_PDM_CLOCK_CONFIG, 8'h43);
    rd(ADDR_PDM_CLOCK_CONFIG, 8'h43);
    wr(ADDR_PDM_INPUT_EDGE_CONFIG, 8'hff);
    rd(ADDR_PDM_INPUT_EDGE_CONFIG, 8'hc0);
    $display("test register access done");
    {role_select, auto_clock_enable, auto_mode_pll_disable} = 3'b011;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      wr(ADDR_CLOCK_SOURCE_CONFIG, {2'b10, k, 3'b000});
      settle();
      `CHK(root_select, ROOT_MCLK)
      `CHK(master_clock_ratio, ratio_tab[i])
      `CHK(pll_enable, 1'b0)
    end
    wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h10);
    settle();
    `CHK(root_select, ROOT_BITCLK)
    `CHK(master_clock_ratio, 12'h000)
    role_select = 1'b1;
    for (int i = 0; i < 8; i++) begin
      master_clock_freq_code = i[2:0];
      settle();
      `CHK(master_clock_khz, khz_tab[i])
      `CHK(master_clock_freq_mode, 1'b0)
    end
    // Multiple mode with ratio code 7 in master role.
    wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h78);
    settle();
    `CHK(master_clock_freq_mode, 1'b1)
    `CHK(master_clock_khz, 16'h0000)
    `CHK(master_clock_ratio, 12'h900)
    auto_clock_enable = 1'b0;
    settle();
    `CHK(pll_enable, 1'b1)
    `CHK(master_clock_freq_mode, 1'b0)
    $display("test clock plan done");
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      role_select = k[2];
      bitclk_in = k[0];
      wr(ADDR_CLOCK_SOURCE_CONFIG, {6'h04, k[1], 1'b0});
      settle();
      settle();
      `CHK(frame_gen_bitclk, k[0] ^ (k[2] & k[1]))
    end
    $display("test frame bit clock done");
    settle();
    `CHK(pdm_clock_out, 1'b0)
    pdm_enable = 1'b1;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      sample_rate_family = k[2];
      // Code 3 is used while only channels 1 and 2 are listened to.
      wr(ADDR_PDM_CLOCK_CONFIG, {6'h10, k[1:0]});
      settle();
      measure(32, cyc);
      exp_cyc = 32'h5f5e1000 / pdm_hz[i];
      `CHK(cyc >= exp_cyc - 2 && cyc <= exp_cyc + 2, 1'b1)
    end
    $display("test pdm clock rates done");
    sample_rate_family = 1'b0;
    wr(ADDR_PDM_CLOCK_CONFIG, 8'h42);
    for (int i = 0; i < 4; i++) begin
      k = i[2:0];
      wr(ADDR_PDM_INPUT_EDGE_CONFIG, {k[1], 7'h00});
      bit_high = k[0];
      bit_low = ~k[0];
      repeat (2) begin
        wait_valid(0);
        wait_valid(1);
      end
      `CHK(pdm_chan_bit[0], k[0] ^ k[1])
      `CHK(pdm_chan_bit[1], ~(k[0] ^ k[1]))
    end
    $display("test latch edges done");
    end_sim();
  end
endmodule

`default_nettype wire
